// *** hdl/gpio_ports.sv ***
// Four bidirectional ports with buzzer pair and interrupt pin
`timescale 1ns/1ps
`default_nettype none
module gpio_ports (
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  // Data memory access from the core
  input wire logic [7:0] ADDR_IN,
  input wire logic WR_IN,
  input wire logic [1:0] OP_IN,
  input wire logic [2:0] BIT_IN,
  input wire logic [7:0] WDATA_IN,
  output logic [7:0] RDATA_OUT,
  output logic HIT_OUT,
  // Configuration options
  input wire logic [7:0] WAKE_EN_A_IN,
  input wire logic [24:0] PULL_EN_IN,
  input wire logic BUZZER_EN_IN,
  input wire logic RC_IO_MODE_IN,
  input wire logic HALTED_IN,
  // Tone from timer overflow
  input wire logic TONE_IN,
  // Pads
  input wire logic [7:0] PA_PAD_IN,
  input wire logic [7:0] PB_PAD_IN,
  input wire logic [5:0] PC_PAD_IN,
  input wire logic [2:0] PG_PAD_IN,
  output logic [7:0] PA_OUT,
  output logic [7:0] PA_OE_OUT,
  output logic [7:0] PB_OUT,
  output logic [7:0] PB_OE_OUT,
  output logic [5:0] PC_OUT,
  output logic [5:0] PC_OE_OUT,
  output logic [2:0] PG_OUT,
  output logic [2:0] PG_OE_OUT,
  output logic [24:0] PULL_ON_OUT,
  // Events
  output logic WAKE_OUT,
  output logic EXT_INT_OUT
);
  logic [7:0] sa, sb, sc, sg;
  logic [24:0] sync_all;
  logic [7:0] la, lb, lc, lg;
  logic [7:0] da, db, dc, dg;
  logic [7:0] ra, rb, rc, rg;
  logic ha, hb, hc, hg;
  logic int_prev_q;
  logic [7:0] a_prev_q;
  logic [2:0] g_io;
  logic bz_true_d;
  logic bz_inv_d;

  // [R3] pads pass two flops then are read directly, no read latch
  pad_sync #(.WIDTH(25)) u_sync (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(RST_N_IN),
    .async_in({PG_PAD_IN, PC_PAD_IN, PB_PAD_IN, PA_PAD_IN}),
    .sync_out(sync_all)
  ); // R3
  assign sa = sync_all[7:0];
  assign sb = sync_all[15:8];
  assign sc = {2'b00, sync_all[21:16]};
  assign sg = {5'b00000, sync_all[24:22]};

  port_reg #(.MASK(gpio_pkg::MASK_A), .DATA_ADDR(gpio_pkg::ADDR_A_DATA),
    .DIR_ADDR(gpio_pkg::ADDR_A_DIR)) u_pa (
    .clk_in(CLK_SYS_IN), .rst_n_in(RST_N_IN), .addr_in(ADDR_IN),
    .wr_in(WR_IN), .op_in(OP_IN), .bit_in(BIT_IN), .wdata_in(WDATA_IN),
    .pad_in(sa), .latch_out(la), .dir_out(da), .rdata_out(ra),
    .hit_out(ha)); // R1 R2
  port_reg #(.MASK(gpio_pkg::MASK_B), .DATA_ADDR(gpio_pkg::ADDR_B_DATA),
    .DIR_ADDR(gpio_pkg::ADDR_B_DIR)) u_pb (
    .clk_in(CLK_SYS_IN), .rst_n_in(RST_N_IN), .addr_in(ADDR_IN),
    .wr_in(WR_IN), .op_in(OP_IN), .bit_in(BIT_IN), .wdata_in(WDATA_IN),
    .pad_in(sb), .latch_out(lb), .dir_out(db), .rdata_out(rb),
    .hit_out(hb)); // R1 R2
  port_reg #(.MASK(gpio_pkg::MASK_C), .DATA_ADDR(gpio_pkg::ADDR_C_DATA),
    .DIR_ADDR(gpio_pkg::ADDR_C_DIR)) u_pc (
    .clk_in(CLK_SYS_IN), .rst_n_in(RST_N_IN), .addr_in(ADDR_IN),
    .wr_in(WR_IN), .op_in(OP_IN), .bit_in(BIT_IN), .wdata_in(WDATA_IN),
    .pad_in(sc), .latch_out(lc), .dir_out(dc), .rdata_out(rc),
    .hit_out(hc)); // R1 R2 R19
  port_reg #(.MASK(gpio_pkg::MASK_G), .DATA_ADDR(gpio_pkg::ADDR_G_DATA),
    .DIR_ADDR(gpio_pkg::ADDR_G_DIR)) u_pg (
    .clk_in(CLK_SYS_IN), .rst_n_in(RST_N_IN), .addr_in(ADDR_IN),
    .wr_in(WR_IN), .op_in(OP_IN), .bit_in(BIT_IN), .wdata_in(WDATA_IN),
    .pad_in(sg), .latch_out(lg), .dir_out(dg), .rdata_out(rg),
    .hit_out(hg)); // R1 R2 R11

  // Read data is combinational so a read sees the current pad sample
  assign RDATA_OUT = ra | rb | rc | rg;
  assign HIT_OUT = ha | hb | hc | hg;

  // [R7] push-pull: enable is the plain inverse of the direction bit
  assign PA_OUT = la;
  assign PA_OE_OUT = ~da; // R5 R7
  assign PC_OUT = lc[5:0];
  assign PC_OE_OUT = ~dc[5:0]; // R7

  // Buzzer pair: gating only from the first line's latch bit
  always_comb begin
    bz_true_d = lb[gpio_pkg::BZ_TRUE_BIT] & TONE_IN; // R14 R15
    bz_inv_d = lb[gpio_pkg::BZ_TRUE_BIT] & ~TONE_IN; // R14 R15
  end

  always_comb begin
    PB_OUT = lb;
    if (BUZZER_EN_IN) begin
      PB_OUT[gpio_pkg::BZ_TRUE_BIT] = bz_true_d; // R13
      PB_OUT[gpio_pkg::BZ_INV_BIT] = bz_inv_d; // R13
    end
  end
  assign PB_OE_OUT = ~db; // R13 R7

  // [R17] oscillator pins give up I/O unless internal RC plus I/O
  assign g_io = {RC_IO_MODE_IN, RC_IO_MODE_IN, 1'b1};
  assign PG_OUT = lg[2:0];
  assign PG_OE_OUT = ~dg[2:0] & g_io; // R17 R16

  // [R12] pull-high per line, dropped on disabled oscillator pins
  assign PULL_ON_OUT = PULL_EN_IN & {g_io, 6'h3f, 8'hff, 8'hff}; // R12 R17

  // Edge history for interrupt and wake detection
  // Histories reset to the synchroniser's zero, so release gives no false fall
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      int_prev_q <= 1'b0;
    end else begin
      int_prev_q <= sg[gpio_pkg::G_INT_BIT];
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      a_prev_q <= '0;
    end else begin
      a_prev_q <= sa;
    end
  end

  // Interrupt pin works whatever the line direction, as the pin is shared
  assign EXT_INT_OUT = int_prev_q & ~sg[gpio_pkg::G_INT_BIT]; // R16 R20
  // Wake on any change of an enabled port A input line while halted
  assign WAKE_OUT = HALTED_IN &
    (|((sa ^ a_prev_q) & WAKE_EN_A_IN & da)); // R10

  a_int_fall: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    EXT_INT_OUT |-> $past(sg[0]) && !sg[0]) // R20
    else $error("interrupt without falling edge");
  a_bz_gate: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    BUZZER_EN_IN && !lb[0] |-> !PB_OUT[0] && !PB_OUT[1]) // R14
    else $error("buzzer not gated low");
  a_bz_pair: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    BUZZER_EN_IN && lb[0] |-> PB_OUT[0] == TONE_IN &&
    PB_OUT[1] == !TONE_IN) // R15
    else $error("buzzer tone wrong");
  a_osc_off: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    !RC_IO_MODE_IN |-> PG_OE_OUT[2:1] == 2'b00 &&
    PULL_ON_OUT[24:23] == 2'b00) // R17
    else $error("oscillator pins driven");
  a_dir_drive: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    WR_IN && ADDR_IN == gpio_pkg::ADDR_A_DIR && OP_IN == 2'b00 |=>
    PA_OE_OUT == ~$past(WDATA_IN)) // R5
    else $error("direction write not applied");
  a_wake_src: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    WAKE_OUT |-> HALTED_IN && (WAKE_EN_A_IN != 8'h00)) // R10
    else $error("wake without enabled source");
endmodule // gpio_ports
`default_nettype wire

// *** hdl/gpio_pkg.sv ***
// Constants shared by the port block and its helpers
// Summary of operation
// [R1] Twenty-five lines in four ports, data latches at 12H, 14H, 16H, 1EH.
// [R2] Per-bit direction registers at 13H, 15H, 17H and 1FH.
// [R3] Inputs unlatched; pad sampled at read, must be valid at phase two. The code reads the pad through pad_sync, two clocks late.
// [R4] Output latch holds written data until the next write.
// [R5] Direction bit 1 makes an input, 0 an output; changeable anytime.
// [R6] Read returns pad when direction is 1, latch when direction is 0.
// [R7] Output lines always drive push-pull; no open-drain mode.
// [R8] Single latch bits can be set or cleared by bit instructions.
// [R9] Read-modify-write reads whole port then writes result back.
// [R10] Each port A line can wake from halt, enabled per line by option.
// [R11] Upper five port G bits read zero and ignore writes.
// [R12] Per-line pull-high option; without it an input line floats.
// [R13] Buzzer option drives tone on two port B lines when outputs.
// [R14] Buzzer gating comes only from the first buzzer line data bit.
// [R15] First line: 0 low, 1 tone; second line low or inverted tone.
// [R16] Port G line 0 shares its pin with the external interrupt.
// [R17] Port G lines 1, 2 are I/O only in internal-RC-plus-I/O mode.
// [R18] Software should set unused lines as outputs to save power.
// [R19] Registers eight bits; missing port C and G bits read zero.
// [R20] External interrupt requests on a falling edge of the pin.
package gpio_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_A_DATA = 8'h12;
  localparam logic [7:0] ADDR_A_DIR = 8'h13;
  localparam logic [7:0] ADDR_B_DATA = 8'h14;
  localparam logic [7:0] ADDR_B_DIR = 8'h15;
  localparam logic [7:0] ADDR_C_DATA = 8'h16;
  localparam logic [7:0] ADDR_C_DIR = 8'h17;
  localparam logic [7:0] ADDR_G_DATA = 8'h1e;
  localparam logic [7:0] ADDR_G_DIR = 8'h1f;
  // Implemented-bit masks
  localparam logic [7:0] MASK_A = 8'hff;
  localparam logic [7:0] MASK_B = 8'hff;
  localparam logic [7:0] MASK_C = 8'h3f;
  localparam logic [7:0] MASK_G = 8'h07;
  // Reset: all lines input, latches high
  localparam logic [7:0] RESET_VAL = 8'hff;
  localparam int unsigned BZ_TRUE_BIT = 0;
  localparam int unsigned BZ_INV_BIT = 1;
  localparam int unsigned G_INT_BIT = 0;
  localparam int unsigned G_CRYSTAL_IN_PIN_BIT = 1;
  localparam int unsigned G_CRYSTAL_OUT_PIN_BIT = 2;
  // Bus operation codes
  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_SET = 2'b01,
    OP_CLR = 2'b10,
    OP_CPL = 2'b11
  } port_op_e;
endpackage

// *** hdl/pad_sync.sv ***
// Two-stage synchroniser for a bus of pad inputs
`timescale 1ns/1ps
`default_nettype none
module pad_sync #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule // pad_sync
`default_nettype wire

// *** hdl/port_reg.sv ***
// One port: output latch, direction register and read mux
`timescale 1ns/1ps
`default_nettype none
module port_reg #(
  parameter logic [7:0] MASK = 8'hff,
  parameter logic [7:0] DATA_ADDR = 8'h12,
  parameter logic [7:0] DIR_ADDR = 8'h13
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Access
  input wire logic [7:0] addr_in,
  input wire logic wr_in,
  input wire logic [1:0] op_in,
  input wire logic [2:0] bit_in,
  input wire logic [7:0] wdata_in,
  // Pads
  input wire logic [7:0] pad_in,
  // State
  output logic [7:0] latch_out,
  output logic [7:0] dir_out,
  output logic [7:0] rdata_out,
  output logic hit_out
);
  logic [7:0] latch_q;
  logic [7:0] dir_q;
  logic [7:0] view;
  logic [7:0] mod_data;
  logic [7:0] onehot;

  // [R6] per-bit read source; [R3] pad not latched here beyond sync
  assign view = ((dir_q & pad_in) | (~dir_q & latch_q)) & MASK; // R6
  assign onehot = 8'h01 << bit_in;

  // [R9] modify the whole read value, then write back
  always_comb begin
    mod_data = wdata_in;
    unique case (gpio_pkg::port_op_e'(op_in))
      gpio_pkg::OP_WRITE: mod_data = wdata_in;
      gpio_pkg::OP_SET: mod_data = view | onehot; // R8
      gpio_pkg::OP_CLR: mod_data = view & ~onehot; // R8
      gpio_pkg::OP_CPL: mod_data = ~view; // R9
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      latch_q <= gpio_pkg::RESET_VAL & MASK;
    end else if (wr_in && addr_in == DATA_ADDR) begin
      latch_q <= mod_data & MASK; // R4 R11 R19
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dir_q <= gpio_pkg::RESET_VAL & MASK;
    end else if (wr_in && addr_in == DIR_ADDR &&
                 gpio_pkg::port_op_e'(op_in) == gpio_pkg::OP_WRITE) begin
      dir_q <= wdata_in & MASK; // R5 R19
    end
  end

  always_comb begin
    hit_out = 1'b1;
    rdata_out = 8'h00;
    if (addr_in == DATA_ADDR) begin
      rdata_out = view;
    end else if (addr_in == DIR_ADDR) begin
      rdata_out = dir_q & MASK;
    end else begin
      hit_out = 1'b0;
    end
  end

  assign latch_out = latch_q;
  assign dir_out = dir_q;

  a_latch_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !(wr_in && addr_in == DATA_ADDR) |=> $stable(latch_q)) // R4
    else $error("latch changed without write");
  a_unused_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ((latch_q | dir_q | rdata_out) & ~MASK) == 8'h00) // R11
    else $error("unimplemented bit nonzero");
  a_read_mux: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    addr_in == DATA_ADDR |->
    rdata_out == (((dir_q & pad_in) | (~dir_q & latch_q)) & MASK)) // R6
    else $error("read mux wrong");
  a_bit_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_in && addr_in == DATA_ADDR && op_in == 2'b01 |=>
    latch_q[$past(bit_in)] == MASK[$past(bit_in)]) // R8
    else $error("bit set failed");
endmodule // port_reg
`default_nettype wire

// *** test/pin_model.sv ***
// Pin model: resolves every pad from device drive, pull and outside source
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  // Device side
  input wire logic [24:0] drv_in,
  input wire logic [24:0] oe_in,
  input wire logic [24:0] pull_in,
  // Outside source
  input wire logic [24:0] ext_in,
  input wire logic [24:0] ext_en_in,
  output logic [24:0] pad_out
);
  // A floating line shows the inverse of the drive, so no stale level passes
  always_comb begin
    for (int i = 0; i < 25; i++) begin
      if (oe_in[i]) pad_out[i] = drv_in[i];
      else if (ext_en_in[i]) pad_out[i] = ext_in[i];
      else if (pull_in[i]) pad_out[i] = 1'b1;
      else pad_out[i] = ~drv_in[i];
    end
  end
endmodule // pin_model
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the four-port block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, bz = 1'b0, rcio = 1'b1;
  logic halted = 1'b0, tone = 1'b0, hit, wake, eint;
  logic [7:0] addr = 8'h00, wdata = 8'h00, wake_en = 8'h00, rdata;
  logic [1:0] op = 2'b00;
  logic [2:0] bitn = 3'h0;
  logic [24:0] pull = 25'h1ffffff, ext = 25'h0, ext_en = 25'h0, pad;
  wire [24:0] drv, oe, pull_on;
  logic [7:0] adr [8] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h1e,
    8'h1f};
  logic [7:0] rst_v [8] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h3f, 8'h07,
    8'h07};
  int err_count = 0, num_checks = 0;
  gpio_ports i_dut (
    .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WR_IN(wr),
    .OP_IN(op), .BIT_IN(bitn), .WDATA_IN(wdata), .RDATA_OUT(rdata),
    .HIT_OUT(hit), .WAKE_EN_A_IN(wake_en), .PULL_EN_IN(pull),
    .BUZZER_EN_IN(bz), .RC_IO_MODE_IN(rcio), .HALTED_IN(halted),
    .TONE_IN(tone), .PA_PAD_IN(pad[7:0]), .PB_PAD_IN(pad[15:8]),
    .PC_PAD_IN(pad[21:16]), .PG_PAD_IN(pad[24:22]), .PA_OUT(drv[7:0]),
    .PA_OE_OUT(oe[7:0]), .PB_OUT(drv[15:8]), .PB_OE_OUT(oe[15:8]),
    .PC_OUT(drv[21:16]), .PC_OE_OUT(oe[21:16]), .PG_OUT(drv[24:22]),
    .PG_OE_OUT(oe[24:22]), .PULL_ON_OUT(pull_on), .WAKE_OUT(wake),
    .EXT_INT_OUT(eint));
  pin_model i_pins (.drv_in(drv), .oe_in(oe), .pull_in(pull_on),
    .ext_in(ext), .ext_en_in(ext_en), .pad_out(pad));
  initial forever #10 clk = ~clk;
  task automatic check(input logic [24:0] seen, input logic [24:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic put(input logic [7:0] a, input logic [1:0] o,
    input logic [2:0] b, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    op <= o;
    bitn <= b;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    #1;
  endtask
  // Pulses last one cycle, so every cycle is looked at
  task automatic await(ref logic s);
    num_checks++;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      #1;
      if (s === 1'b1) return;
    end
    err_count++;
    $display("[ERR] %0t expected pulse never came", $time);
    summarize();
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check(oe, 25'h0);
    // Pads need two edges to pass the synchroniser before a read
    repeat (2) @(posedge clk);
    #1;
    check({eint, wake}, 2'b00);
    foreach (adr[i]) begin
      rd(adr[i]);
      check(rdata, rst_v[i]);
      check(hit, 1'b1);
    end
    rd(8'h20);
    check({hit, rdata}, 9'h0);
    // Low nibble driven, high nibble read back from the pads
    put(8'h13, 2'b00, 3'h0, 8'hf0);
    put(8'h12, 2'b00, 3'h0, 8'ha5);
    ext_en[7:0] <= 8'hff;
    ext[7:0] <= 8'h3c;
    repeat (3) @(posedge clk);
    rd(8'h12);
    check(rdata, 8'h35);
    check(oe[7:0], 8'h0f);
    check(drv[3:0], 4'h5);
    put(8'h13, 2'b00, 3'h0, 8'h00);
    rd(8'h12);
    check(rdata, 8'ha5);
    // Bit operations on an all-output port
    put(8'h15, 2'b00, 3'h0, 8'h00);
    put(8'h14, 2'b00, 3'h0, 8'h00);
    put(8'h14, 2'b01, 3'h3, 8'h00);
    rd(8'h14);
    check(rdata, 8'h08);
    put(8'h14, 2'b10, 3'h3, 8'h00);
    rd(8'h14);
    check(rdata, 8'h00);
    put(8'h14, 2'b11, 3'h0, 8'h00);
    rd(8'h14);
    check(rdata, 8'hff);
    put(8'h17, 2'b00, 3'h0, 8'h00);
    put(8'h16, 2'b00, 3'h0, 8'hff);
    rd(8'h16);
    check(rdata, 8'h3f);
    put(8'h1f, 2'b00, 3'h0, 8'h00);
    put(8'h1e, 2'b00, 3'h0, 8'hff);
    rd(8'h1e);
    check(rdata, 8'h07);
    rd(8'h1f);
    check(rdata, 8'h00);
    check(drv[24:16], 9'h1ff);
    check(oe[24:22], 3'h7);
    rcio <= 1'b0;
    @(posedge clk);
    #1;
    check({oe[24:23], pull_on[24:23]}, 4'h0);
    rcio <= 1'b1;
    // Falling pin on the shared interrupt line
    put(8'h1f, 2'b00, 3'h0, 8'h07);
    ext_en[22] <= 1'b1;
    ext[22] <= 1'b1;
    repeat (4) @(posedge clk);
    ext[22] <= 1'b0;
    await(eint);
    // Buzzer pair follows the tone, gated by the first line only
    bz <= 1'b1;
    put(8'h14, 2'b00, 3'h0, 8'h01);
    for (int v = 0; v < 2; v++) begin
      tone <= v[0];
      @(posedge clk);
      #1;
      check(drv[9:8], {~v[0], v[0]});
    end
    put(8'h14, 2'b00, 3'h0, 8'h02);
    #1;
    check(drv[9:8], 2'b00);
    put(8'h15, 2'b00, 3'h0, 8'h02);
    #1;
    check(oe[9:8], 2'b01);
    // Wake from halt on an enabled port A input
    put(8'h13, 2'b00, 3'h0, 8'hff);
    wake_en <= 8'h10;
    repeat (4) @(posedge clk);
    halted <= 1'b1;
    @(posedge clk);
    ext[4] <= 1'b0;
    await(wake);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
